// [rtl/ecl_config_loader.sv]
// Notes on behaviour
// - first checksum word: vital high, configurable low
// - checksum byte is XOR of covered bytes
// - second checksum word covers its own ranges
// - setup register loads from words 12h, 13h
// - setup register reached as two 16-bit halves
// - reserved setup bits always read zero
// - bits 17-16 pick the RAM split
// - bit 9 wake enable, allows attribute access
// - after woken access, chip returns to sleep
// - bit 8 power-saving level, resets conservative
// - bits 5-0 stored but without effect
// - capability word fixed: bits 13, 7, 1
// - revision bits 15:14 power mode, 13:5 zero
// - revision bit 4 marks boot ROM fitted
// - revision bits 3:0 hold revision code
// - card info bytes at even addresses only
// - address word loaded, bits 15-14 transceiver
//
// The register offsets and the APB register port are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none

module ecl_config_loader
  import ecl_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             ee_cs,
  output logic             ee_sk,
  output logic             ee_di,
  input  wire logic        ee_do,
  input  wire logic        auto_pd,
  input  wire logic        attr_req,
  input  wire logic        attr_we,
  input  wire logic [8:0]  attr_addr,
  input  wire logic [7:0]  attr_wdata,
  output logic      [7:0]  attr_rdata,
  output logic             attr_ack,
  output logic             wake_req,
  output logic      [1:0]  tx_rx_ram_split,
  output logic             power_saving_level,
  output logic             wake_en,
  output logic      [1:0]  transceiver_choice,
  output logic             load_busy,
  output logic             irq
);

  // ---------------------------------------------------------------
  // Checksum coverage
  // ---------------------------------------------------------------
  function automatic logic is_conf_a(input logic [5:0] w);
    is_conf_a = (w == ECL_W_ADDR_CFG) || (w == ECL_W_RES_CFG) ||
                (w == ECL_W_SW_INFO);
  endfunction
  function automatic logic is_vital_a(input logic [5:0] w);
    is_vital_a = (w <= ECL_W_VITAL_END) && !is_conf_a(w);
  endfunction
  function automatic logic is_vital_b(input logic [5:0] w);
    is_vital_b = (w >= ECL_W_CAPS && w <= ECL_W_SETUP_LO) ||
                 (w >= ECL_W_HIGH_BEG);
  endfunction
  function automatic logic is_conf_b(input logic [5:0] w);
    is_conf_b = (w >= ECL_W_SETUP_HI) && (w <= ECL_W_CONF2_END);
  endfunction
  function automatic logic [7:0] fold(input logic [15:0] d);
    fold = d[15:8] ^ d[7:0];
  endfunction

  // ---------------------------------------------------------------
  // EEPROM loader
  // ---------------------------------------------------------------
  ecl_state_e  st_reg, st_next;
  logic [5:0]  half_reg, half_next;
  logic        sk_reg, sk_next;
  logic [4:0]  bit_reg, bit_next;
  logic [5:0]  word_reg, word_next;
  logic [15:0] sh_reg, sh_next;
  logic        cs_reg, cs_next;
  logic        di_reg, di_next;
  logic        start_reg, start_next;
  ecl_acc_s    acc_reg, acc_next;
  logic [15:0] sum_a_reg, sum_a_next;
  logic [15:0] sum_b_reg, sum_b_next;
  logic [15:0] s_lo_reg, s_lo_next;
  logic [15:0] s_hi_reg, s_hi_next;
  logic [15:0] s_adr_reg, s_adr_next;
  logic [15:0] s_rev_reg, s_rev_next;
  ecl_csum_s   err_reg, err_next;
  logic        commit;
  logic [15:0] word_in;
  logic [8:0]  cmd;
  logic        ctrl_kick;
  assign cmd     = {ECL_EE_READ_OP, word_reg};
  assign word_in = {sh_reg[14:0], ee_do};
  always_comb begin
    st_next    = st_reg;
    half_next  = half_reg;
    sk_next    = sk_reg;
    bit_next   = bit_reg;
    word_next  = word_reg;
    sh_next    = sh_reg;
    cs_next    = cs_reg;
    di_next    = di_reg;
    start_next = start_reg | ctrl_kick;
    acc_next   = acc_reg;
    sum_a_next = sum_a_reg;
    sum_b_next = sum_b_reg;
    s_lo_next  = s_lo_reg;
    s_hi_next  = s_hi_reg;
    s_adr_next = s_adr_reg;
    s_rev_next = s_rev_reg;
    err_next   = err_reg;
    commit     = 1'b0;
    case (st_reg)
      ECL_ST_IDLE: begin
        if (start_reg) begin
          start_next = ctrl_kick;
          st_next    = ECL_ST_GAP;
          word_next  = 6'h00;
          acc_next   = '0;
          half_next  = 6'h00;
        end
      end
      ECL_ST_GAP: begin
        cs_next   = 1'b0;
        half_next = half_reg + 6'h01;
        if (half_reg == ECL_SK_HALF_CYC - 6'h01) begin
          half_next = 6'h00;
          st_next   = ECL_ST_BITS;
          cs_next   = 1'b1;
          bit_next  = 5'h00;
          di_next   = cmd[8];
        end
      end
      ECL_ST_BITS: begin
        half_next = half_reg + 6'h01;
        if (half_reg == ECL_SK_HALF_CYC - 6'h01) begin
          half_next = 6'h00;
          sk_next   = ~sk_reg;
          if (sk_reg) begin
            bit_next = bit_reg + 5'h01;
            if (bit_reg >= ECL_EE_CMD_BITS)
              sh_next = word_in;
            if (bit_reg + 5'h01 < ECL_EE_CMD_BITS)
              di_next = cmd[4'(5'h07 - bit_reg)];
            else
              di_next = 1'b0;
            if (bit_reg == ECL_EE_LAST_BIT) begin
              if (is_vital_a(word_reg))
                acc_next.vital_a = acc_reg.vital_a ^ fold(word_in);
              if (is_conf_a(word_reg))
                acc_next.conf_a = acc_reg.conf_a ^ fold(word_in);
              if (is_vital_b(word_reg))
                acc_next.vital_b = acc_reg.vital_b ^ fold(word_in);
              if (is_conf_b(word_reg))
                acc_next.conf_b = acc_reg.conf_b ^ fold(word_in);
              case (word_reg)
                ECL_W_CSUM1:    sum_a_next = word_in;
                ECL_W_CSUM2:    sum_b_next = word_in;
                ECL_W_SETUP_LO: s_lo_next  = word_in;
                ECL_W_SETUP_HI: s_hi_next  = word_in;
                ECL_W_ADDR_CFG: s_adr_next = word_in;
                ECL_W_REV:      s_rev_next = word_in;
                default: ;
              endcase
              word_next = word_reg + 6'h01;
              st_next   = (word_reg == ECL_W_LAST) ? ECL_ST_END
                                                   : ECL_ST_GAP;
              cs_next   = 1'b0;
            end
          end
        end
      end
      ECL_ST_END: begin
        err_next.vital_a = acc_reg.vital_a != sum_a_reg[15:8];
        err_next.conf_a  = acc_reg.conf_a  != sum_a_reg[7:0];
        err_next.vital_b = acc_reg.vital_b != sum_b_reg[15:8];
        err_next.conf_b  = acc_reg.conf_b  != sum_b_reg[7:0];
        commit  = 1'b1;
        st_next = ECL_ST_IDLE;
      end
      default: st_next = ECL_ST_IDLE;
    endcase
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_reg    <= ECL_ST_IDLE;
      half_reg  <= 6'h00;
      sk_reg    <= 1'b0;
      bit_reg   <= 5'h00;
      word_reg  <= 6'h00;
      sh_reg    <= 16'h0000;
      cs_reg    <= 1'b0;
      di_reg    <= 1'b0;
      start_reg <= 1'b1;
      acc_reg   <= '0;
      sum_a_reg <= 16'h0000;
      sum_b_reg <= 16'h0000;
      s_lo_reg  <= ECL_SETUP_LO_RST;
      s_hi_reg  <= ECL_SETUP_HI_RST;
      s_adr_reg <= ECL_ADDR_CFG_RST;
      s_rev_reg <= ECL_REV_RST;
      err_reg   <= '0;
    end else begin
      st_reg    <= st_next;
      half_reg  <= half_next;
      sk_reg    <= sk_next;
      bit_reg   <= bit_next;
      word_reg  <= word_next;
      sh_reg    <= sh_next;
      cs_reg    <= cs_next;
      di_reg    <= di_next;
      start_reg <= start_next;
      acc_reg   <= acc_next;
      sum_a_reg <= sum_a_next;
      sum_b_reg <= sum_b_next;
      s_lo_reg  <= s_lo_next;
      s_hi_reg  <= s_hi_next;
      s_adr_reg <= s_adr_next;
      s_rev_reg <= s_rev_next;
      err_reg   <= err_next;
    end
  end
  assign ee_cs = cs_reg;
  assign ee_sk = sk_reg;
  assign ee_di = di_reg;

  // ---------------------------------------------------------------
  // Attribute memory and wakeup
  // ---------------------------------------------------------------
  logic [7:0] cis_mem [0:255];
  logic       ack_reg, ack_next;
  logic [7:0] ard_reg, ard_next;
  logic       wake_reg, wake_next;
  logic       mem_we;
  logic       ev_wake;
  logic       wake_en_bit;

  always_comb begin
    ack_next  = 1'b0;
    ard_next  = ard_reg;
    wake_next = wake_reg;
    mem_we    = 1'b0;
    ev_wake   = 1'b0;
    if (attr_req && !ack_reg) begin
      ack_next  = 1'b1;
      ard_next  = 8'h00;
      wake_next = auto_pd && wake_en_bit;
      if ((!auto_pd || wake_en_bit) && !attr_addr[0]) begin
        ard_next = cis_mem[attr_addr[8:1]];
        mem_we   = attr_we;
      end
    end
    if (ack_reg && wake_reg) begin
      wake_next = 1'b0;
      ev_wake   = 1'b1;
    end
  end
  always_ff @(posedge clk) begin
    if (mem_we)
      cis_mem[attr_addr[8:1]] <= attr_wdata;
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ack_reg  <= 1'b0;
      ard_reg  <= 8'h00;
      wake_reg <= 1'b0;
    end else begin
      ack_reg  <= ack_next;
      ard_reg  <= ard_next;
      wake_reg <= wake_next;
    end
  end
  assign attr_ack   = ack_reg;
  assign attr_rdata = ard_reg;
  assign wake_req   = wake_reg;

  // ---------------------------------------------------------------
  // APB registers and interrupt
  // ---------------------------------------------------------------
  logic [15:0] lo_reg, lo_next;
  logic [15:0] hi_reg, hi_next;
  logic [15:0] adr_reg, adr_next;
  logic [15:0] rev_reg, rev_next;
  logic [2:0]  ist_reg, ist_next;
  logic [2:0]  imsk_reg, imsk_next;
  logic        irq_reg, irq_next;
  logic        rdy_reg, rdy_next;
  logic        err_o_reg, err_o_next;
  logic [31:0] rd_reg, rd_next;
  logic        busy_reg, busy_next;
  logic        wr;
  logic [2:0]  ev;
  logic [31:0] rmux;
  logic        hit;
  assign wr          = psel && penable && rdy_reg && pwrite;
  assign wake_en_bit = lo_reg[ECL_WAKE_BIT];
  assign ctrl_kick   = wr && (paddr == ECL_A_CTRL) && pwdata[0];
  assign ev = {ev_wake, commit && (err_next != '0), commit};
  always_comb begin
    hit  = 1'b1;
    rmux = 32'h0000_0000;
    case (paddr)
      ECL_A_SETUP_LO: rmux[15:0] = lo_reg;
      ECL_A_SETUP_HI: rmux[15:0] = hi_reg;
      ECL_A_CAPS:     rmux[15:0] = ECL_CAPS_VALUE;
      ECL_A_REV:      rmux[15:0] = rev_reg;
      ECL_A_ADDR_CFG: rmux[15:0] = adr_reg;
      ECL_A_STATUS:   rmux[5:0]  = {busy_reg, err_reg, 1'b0};
      ECL_A_INT_STAT: rmux[2:0]  = ist_reg;
      ECL_A_INT_MASK: rmux[2:0]  = imsk_reg;
      ECL_A_CTRL:     rmux[0]    = 1'b0;
      default:        hit        = 1'b0;
    endcase
  end
  always_comb begin
    lo_next    = lo_reg;
    hi_next    = hi_reg;
    adr_next   = adr_reg;
    rev_next   = rev_reg;
    imsk_next  = imsk_reg;
    ist_next   = ist_reg;
    busy_next  = (st_next != ECL_ST_IDLE) || start_next;
    rdy_next   = psel && penable && !rdy_reg;
    err_o_next = rdy_next && !hit;
    rd_next    = rdy_next && hit && !pwrite ? rmux : 32'h0000_0000;
    if (wr) begin
      case (paddr)
        ECL_A_SETUP_LO:
          lo_next = pwdata[15:0] & ECL_SETUP_LO_WMASK;
        ECL_A_SETUP_HI:
          hi_next = pwdata[15:0] & ECL_SETUP_HI_WMASK;
        ECL_A_ADDR_CFG:
          adr_next = pwdata[15:0] & ECL_ADDR_CFG_WMASK;
        ECL_A_INT_STAT: ist_next = ist_reg & ~pwdata[2:0];
        ECL_A_INT_MASK: imsk_next = pwdata[2:0];
        default: ;
      endcase
    end
    ist_next = ist_next | ev;
    if (commit) begin
      lo_next  = s_lo_reg & ECL_SETUP_LO_WMASK;
      hi_next  = s_hi_reg & ECL_SETUP_HI_WMASK;
      adr_next = s_adr_reg & ECL_ADDR_CFG_WMASK;
      rev_next = s_rev_reg & ECL_REV_MASK;
    end
    irq_next = |(ist_next & imsk_next);
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      lo_reg    <= ECL_SETUP_LO_RST;
      hi_reg    <= ECL_SETUP_HI_RST;
      adr_reg   <= ECL_ADDR_CFG_RST;
      rev_reg   <= ECL_REV_RST;
      ist_reg   <= ECL_INT_RST;
      imsk_reg  <= ECL_INT_RST;
      irq_reg   <= 1'b0;
      rdy_reg   <= 1'b0;
      err_o_reg <= 1'b0;
      rd_reg    <= 32'h0000_0000;
      busy_reg  <= 1'b1;
    end else begin
      lo_reg    <= lo_next;
      hi_reg    <= hi_next;
      adr_reg   <= adr_next;
      rev_reg   <= rev_next;
      ist_reg   <= ist_next;
      imsk_reg  <= imsk_next;
      irq_reg   <= irq_next;
      rdy_reg   <= rdy_next;
      err_o_reg <= err_o_next;
      rd_reg    <= rd_next;
      busy_reg  <= busy_next;
    end
  end
  assign prdata             = rd_reg;
  assign pready             = rdy_reg;
  assign pslverr            = err_o_reg;
  assign irq                = irq_reg;
  assign load_busy          = busy_reg;
  assign tx_rx_ram_split    = hi_reg[1:0];
  assign power_saving_level = lo_reg[ECL_PSL_BIT];
  assign wake_en            = lo_reg[ECL_WAKE_BIT];
  assign transceiver_choice = adr_reg[ECL_XCVR_LSB +: 2];

endmodule

`default_nettype wire

// [include/ecl_pkg.sv]
package ecl_pkg;

  // ---------------------------------------------------------------
  // Register map (APB byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] ECL_A_SETUP_LO  = 8'h00;
  localparam logic [7:0] ECL_A_SETUP_HI  = 8'h04;
  localparam logic [7:0] ECL_A_CAPS      = 8'h08;
  localparam logic [7:0] ECL_A_REV       = 8'h0c;
  localparam logic [7:0] ECL_A_ADDR_CFG  = 8'h10;
  localparam logic [7:0] ECL_A_STATUS    = 8'h14;
  localparam logic [7:0] ECL_A_INT_STAT  = 8'h18;
  localparam logic [7:0] ECL_A_INT_MASK  = 8'h1c;
  localparam logic [7:0] ECL_A_CTRL      = 8'h20;

  // ---------------------------------------------------------------
  // Field layouts and reset values
  // ---------------------------------------------------------------
  localparam logic [15:0] ECL_SETUP_LO_WMASK = 16'h033f;
  localparam logic [15:0] ECL_SETUP_HI_WMASK = 16'h0003;
  localparam logic [15:0] ECL_ADDR_CFG_WMASK = 16'hffdf;
  localparam logic [15:0] ECL_REV_MASK       = 16'hc01f;
  localparam logic [15:0] ECL_CAPS_VALUE     = 16'h2082;
  localparam logic [15:0] ECL_SETUP_LO_RST   = 16'h0000;
  localparam logic [15:0] ECL_SETUP_HI_RST   = 16'h0000;
  localparam logic [15:0] ECL_ADDR_CFG_RST   = 16'h0000;
  localparam logic [15:0] ECL_REV_RST        = 16'h0000;
  localparam int          ECL_WAKE_BIT       = 9;
  localparam int          ECL_PSL_BIT        = 8;
  localparam int          ECL_XCVR_LSB       = 14;
  localparam int          ECL_IRQ_LOADED     = 0;
  localparam int          ECL_IRQ_CSUM       = 1;
  localparam int          ECL_IRQ_WAKE       = 2;
  localparam logic [2:0]  ECL_INT_RST        = 3'h0;

  // ---------------------------------------------------------------
  // EEPROM word map
  // ---------------------------------------------------------------
  localparam logic [5:0] ECL_W_ADDR_CFG  = 6'h08;
  localparam logic [5:0] ECL_W_RES_CFG   = 6'h09;
  localparam logic [5:0] ECL_W_SW_INFO   = 6'h0d;
  localparam logic [5:0] ECL_W_VITAL_END = 6'h0e;
  localparam logic [5:0] ECL_W_CSUM1     = 6'h0f;
  localparam logic [5:0] ECL_W_CAPS      = 6'h10;
  localparam logic [5:0] ECL_W_SETUP_LO  = 6'h12;
  localparam logic [5:0] ECL_W_SETUP_HI  = 6'h13;
  localparam logic [5:0] ECL_W_REV       = 6'h14;
  localparam logic [5:0] ECL_W_CSUM2     = 6'h17;
  localparam logic [5:0] ECL_W_CONF2_END = 6'h1e;
  localparam logic [5:0] ECL_W_HIGH_BEG  = 6'h20;
  localparam logic [5:0] ECL_W_LAST      = 6'h3f;
  localparam logic [2:0] ECL_EE_READ_OP  = 3'h6;
  localparam logic [4:0] ECL_EE_CMD_BITS = 5'h09;
  localparam logic [4:0] ECL_EE_LAST_BIT = 5'h18;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int         ECL_CLK_NS     = 25;
  localparam int         ECL_SK_HALF_NS = 250;
  localparam logic [5:0] ECL_SK_HALF_CYC =
    6'((ECL_SK_HALF_NS + ECL_CLK_NS - 1) / ECL_CLK_NS);

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    ECL_ST_IDLE = 2'b00,
    ECL_ST_GAP  = 2'b01,
    ECL_ST_BITS = 2'b11,
    ECL_ST_END  = 2'b10
  } ecl_state_e;

  typedef struct packed {
    logic vital_a;
    logic conf_a;
    logic vital_b;
    logic conf_b;
  } ecl_csum_s;

  typedef struct packed {
    logic [7:0] vital_a;
    logic [7:0] conf_a;
    logic [7:0] vital_b;
    logic [7:0] conf_b;
  } ecl_acc_s;

endpackage

// [tb/ecl_config_loader_checker.sv]
`timescale 1ns/10ps
`default_nettype none
module ecl_config_loader_checker
  import ecl_pkg::*;
(
  input wire logic        clk,
  input wire logic        arst_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        auto_pd,
  input wire logic        attr_req,
  input wire logic        attr_we,
  input wire logic [8:0]  attr_addr,
  input wire logic [7:0]  attr_rdata,
  input wire logic        attr_ack,
  input wire logic        wake_req,
  input wire logic        wake_en
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  wire rd = pready && !pwrite;
  // ----------------------------------------
  // Register bus
  // ----------------------------------------
  a_pready_pulse: assert property (pready |=> !pready)
    else $error("pready held past one cycle");
  a_apb_answer: assert property ($rose(penable) && psel |=> pready)
    else $error("late apb answer");
  a_unmapped_err: assert property (pready && paddr > ECL_A_CTRL
    |-> pslverr && prdata == 32'h0) else $error("unmapped not refused");
  a_prdata_idle: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside answer");
  a_caps_fixed: assert property (rd && paddr == ECL_A_CAPS
    |-> prdata == {16'h0, ECL_CAPS_VALUE}) else $error("caps word");
  a_setup_rsvd: assert property (rd && paddr == ECL_A_SETUP_LO
    |-> (prdata & {16'hffff, ~ECL_SETUP_LO_WMASK}) == 32'h0)
    else $error("reserved low setup bits");
  a_split_rsvd: assert property (rd && paddr == ECL_A_SETUP_HI
    |-> prdata[31:2] == 30'h0) else $error("reserved high setup bits");
  a_rev_rsvd: assert property (rd && paddr == ECL_A_REV
    |-> prdata[13:5] == 9'h0) else $error("reserved revision bits");
  // ----------------------------------------
  // Attribute memory
  // ----------------------------------------
  a_attr_answer: assert property (attr_req && !attr_ack |=> attr_ack)
    else $error("late attribute answer");
  a_odd_zero: assert property (attr_ack && !attr_we && attr_addr[0]
    |-> attr_rdata == 8'h0) else $error("odd byte not zero");
  a_sleep_refuse: assert property (attr_ack && auto_pd && !wake_en
    |-> attr_rdata == 8'h0 && !wake_req) else $error("asleep access");
  a_wake_access: assert property (attr_ack && auto_pd && wake_en
    |-> wake_req) else $error("woken access not flagged");
  a_wake_back: assert property (wake_req |=> !wake_req)
    else $error("no return to sleep");
  c_woken: cover property (wake_req);
  c_refused: cover property (pready && pslverr);
  c_odd: cover property (attr_ack && attr_addr[0]);
endmodule
`default_nettype wire

// [tb/ecl_eeprom_model.sv]
`timescale 1ns/10ps
`default_nettype none
module ecl_eeprom_model (
  input  wire logic ee_cs,
  input  wire logic ee_sk,
  input  wire logic ee_di,
  output var  logic ee_do
);
  logic [15:0] mem [64];
  logic [4:0]  cnt;
  logic [5:0]  adr;
  initial begin
    ee_do = 1'b0;
    cnt = 5'h0;
    adr = 6'h0;
  end
  always @(posedge ee_cs) cnt = 5'h0;
  // Released line shows the inverse of the last bit
  always @(negedge ee_cs) ee_do = ~ee_do;
  always @(posedge ee_sk) begin
    if (cnt > 5'h2 && cnt < 5'h9) adr = {adr[4:0], ee_di};
    if (cnt >= 5'h9) ee_do = mem[adr][5'h18 - cnt];
    cnt = cnt + 5'h1;
  end
endmodule
`default_nettype wire

// [tb/ecl_config_loader_tb.sv]
`timescale 1ns/10ps
`default_nettype none
module ecl_config_loader_tb;
  import ecl_pkg::*;
  logic        clk, arst_n, psel, penable, pwrite, pready, pslverr;
  logic        ee_cs, ee_sk, ee_di, ee_do, auto_pd, attr_req, attr_we;
  logic        attr_ack, wake_req, power_saving_level, wake_en, load_busy;
  logic        irq;
  logic [7:0]  paddr, attr_wdata, attr_rdata, vx, cx;
  logic [8:0]  attr_addr;
  logic [31:0] pwdata, prdata;
  logic [1:0]  tx_rx_ram_split, transceiver_choice;
  logic [32:0] apb_q[$];
  logic [7:0]  attr_q[$];
  logic [15:0] w[64];
  int          num_errors, n_tests, seed, i;

  ecl_config_loader DUT (.clk(clk), .arst_n(arst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .ee_cs(ee_cs),
    .ee_sk(ee_sk), .ee_di(ee_di), .ee_do(ee_do), .auto_pd(auto_pd),
    .attr_req(attr_req), .attr_we(attr_we), .attr_addr(attr_addr),
    .attr_wdata(attr_wdata), .attr_rdata(attr_rdata), .attr_ack(attr_ack),
    .wake_req(wake_req), .tx_rx_ram_split(tx_rx_ram_split),
    .power_saving_level(power_saving_level), .wake_en(wake_en),
    .transceiver_choice(transceiver_choice), .load_busy(load_busy),
    .irq(irq));
  ecl_eeprom_model ee (.ee_cs(ee_cs), .ee_sk(ee_sk), .ee_di(ee_di),
    .ee_do(ee_do));

  always #12.5 clk = ~clk;

  task summarize;
    if (num_errors == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic check(input logic ok, input string m);
    n_tests++;
    if (ok !== 1'b1) begin
      num_errors++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask

  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
           input logic [32:0] e);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    if (!wr) apb_q.push_back(e);
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin @(posedge clk); k++; end while (pready !== 1'b1 && k < 20);
    check(k < 20, "no apb answer");
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task attr(input logic we, input logic [8:0] a, input logic [7:0] e);
    int k;
    @(posedge clk);
    attr_req <= 1'b1;
    attr_we <= we;
    attr_addr <= a;
    attr_wdata <= e;
    if (!we) attr_q.push_back(e);
    k = 0;
    do begin @(posedge clk); k++; end while (attr_ack !== 1'b1 && k < 20);
    check(k < 20, "no attribute answer");
    attr_req <= 1'b0;
  endtask

  task wait_load;
    int k;
    k = 0;
    do begin @(posedge clk); k++; end while (load_busy !== 1'b0 && k < 40000);
    check(k < 40000, "load timeout");
  endtask

  // ----------------------------------------
  // Result monitor
  // ----------------------------------------
  always @(posedge clk) begin
    if (pready === 1'b1 && pwrite === 1'b0)
      check({pslverr, prdata} === apb_q.pop_front(), "register read");
    if (attr_ack === 1'b1 && attr_we === 1'b0)
      check(attr_rdata === attr_q.pop_front(), "attribute read");
  end

  initial begin
    repeat (90000) @(posedge clk);
    num_errors++;
    summarize;
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {clk, arst_n, psel, penable, pwrite, auto_pd, attr_req, attr_we} = '0;
    {paddr, pwdata, attr_addr, attr_wdata} = '0;
    num_errors = 0;
    n_tests = 0;
    seed = 69;
    vx = 8'h0;
    cx = 8'h0;
    for (i = 0; i < 64; i++) w[i] = 16'($random(seed));
    for (i = 0; i < 15; i++)
      if (i == 8 || i == 9 || i == 13) cx ^= w[i][15:8] ^ w[i][7:0];
      else vx ^= w[i][15:8] ^ w[i][7:0];
    w[15] = {~vx, cx};
    vx = 8'h0;
    cx = 8'h0;
    for (i = 16; i < 64; i++)
      if (i < 19 || i > 31) vx ^= w[i][15:8] ^ w[i][7:0];
      else if (i < 31 && i != 23) cx ^= w[i][15:8] ^ w[i][7:0];
    w[17] ^= {8'h00, vx ^ cx};
    w[23] = {cx, cx};
    for (i = 0; i < 64; i++) ee.mem[i] = w[i];
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    apb(0, ECL_A_SETUP_LO, 0, 33'h0);
    apb(0, ECL_A_SETUP_HI, 0, 33'h0);
    apb(0, ECL_A_CAPS, 0, {17'h0, ECL_CAPS_VALUE});
    apb(0, 8'h24, 0, {1'b1, 32'h0});
    apb(1, ECL_A_INT_MASK, 32'h7, 0);
    check(wake_en === 1'b0 && power_saving_level === 1'b0, "reset");
    wait_load;
    repeat (2) @(posedge clk);
    check(irq === 1'b1, "load irq");
    apb(0, ECL_A_STATUS, 0, 33'h10);
    apb(0, ECL_A_INT_STAT, 0, 33'h3);
    apb(0, ECL_A_SETUP_LO, 0, {17'h0, w[18] & ECL_SETUP_LO_WMASK});
    apb(0, ECL_A_SETUP_HI, 0, {17'h0, w[19] & ECL_SETUP_HI_WMASK});
    apb(0, ECL_A_REV, 0, {17'h0, w[20] & ECL_REV_MASK});
    apb(0, ECL_A_ADDR_CFG, 0, {17'h0, w[8] & ECL_ADDR_CFG_WMASK});
    check(transceiver_choice === w[8][15:14], "transceiver");
    check(tx_rx_ram_split === w[19][1:0], "loaded split");
    apb(1, ECL_A_INT_STAT, 32'h3, 0);
    repeat (2) @(posedge clk);
    check(irq === 1'b0, "irq clear");
    for (i = 0; i < 4; i++) begin
      apb(1, ECL_A_SETUP_HI, 32'hfffffffc | i, 0);
      apb(0, ECL_A_SETUP_HI, 0, 33'(i));
      check(tx_rx_ram_split === 2'(i), "split");
    end
    apb(1, ECL_A_SETUP_LO, 32'hffffffff, 0);
    apb(0, ECL_A_SETUP_LO, 0, 33'h033f);
    check(wake_en === 1'b1 && power_saving_level === 1'b1, "setup");
    vx = 8'($random(seed));
    attr(1, 9'h010, vx);
    attr(0, 9'h010, vx);
    attr(0, 9'h011, 8'h0);
    auto_pd <= 1'b1;
    attr(0, 9'h010, vx);
    apb(0, ECL_A_INT_STAT, 0, 33'h4);
    apb(1, ECL_A_SETUP_LO, 32'h0, 0);
    attr(0, 9'h010, 8'h0);
    ee.mem[15] = w[15] ^ 16'hff00;
    apb(1, ECL_A_CTRL, 32'h1, 0);
    apb(0, ECL_A_STATUS, 0, 33'h30);
    apb(0, ECL_A_SETUP_LO, 0, 33'h0);
    wait_load;
    apb(0, ECL_A_STATUS, 0, 33'h0);
    apb(0, ECL_A_INT_STAT, 0, 33'h5);
    apb(0, ECL_A_SETUP_LO, 0, {17'h0, w[18] & ECL_SETUP_LO_WMASK});
    summarize;
  end
endmodule
`default_nettype wire

bind ecl_config_loader ecl_config_loader_checker u_chk (.clk(clk),
  .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .auto_pd(auto_pd), .attr_req(attr_req), .attr_we(attr_we),
  .attr_addr(attr_addr), .attr_rdata(attr_rdata), .attr_ack(attr_ack),
  .wake_req(wake_req), .wake_en(wake_en));
